// >>> verilog/tmo_pkg.sv
`default_nettype none
package tmo_pkg;
    // byte addresses on the register bus
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_COUNT_LOW = 8'h04;
    localparam logic [7:0] OFF_COUNT_HIGH = 8'h08;
    localparam logic [7:0] OFF_ROLLOVER = 8'h0C;
    localparam logic [7:0] OFF_WATCHDOG = 8'h10;
    localparam logic [7:0] OFF_PORT_C = 8'h14;
    // timer_one_control fields
    localparam int CTRL_WIDE = 7;
    localparam int CTRL_SYSCLK = 6;
    localparam int CTRL_DIV_HI = 5;
    localparam int CTRL_DIV_LO = 4;
    localparam int CTRL_OSC_EN = 3;
    localparam int CTRL_SYNC_BYP = 2;
    localparam int CTRL_SRC = 1;
    localparam int CTRL_RUN = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // rollover register fields
    localparam int ROLL_FLAG = 0;
    localparam int ROLL_IRQ_EN = 1;
    // watchdog_control alternate-register select
    localparam int WDT_ALT_SEL = 4;
    // port_c_direction register fields
    localparam int PORT_DIR_LO = 0;
    localparam int PORT_LATCH_LO = 4;
    localparam int PORT_PIN_LO = 8;
    localparam logic [1:0] PORT_DIR_RESET = 2'h3;
    localparam logic [1:0] PORT_LATCH_RESET = 2'h0;
    // count
    localparam int COUNT_W = 16;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    // one instruction cycle is four system clocks
    localparam int INSTR_CLKS = 4;
    localparam logic [1:0] INSTR_LAST = 2'(INSTR_CLKS - 1);
    // synchroniser lanes
    localparam int SYN_OSC_IN = 0;
    localparam int SYN_EXT_PIN = 1;
    localparam int SYN_SYSCLK = 2;
    localparam int SYN_W = 3;
endpackage
`default_nettype wire

// >>> verilog/tmo_sync2.sv
`timescale 1ns/100ps
`default_nettype none
module tmo_sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // async in, synced out
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] q_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= '0;
            q_reg <= '0;
        end
        else
        begin
            meta_reg <= d;
            q_reg <= meta_reg;
        end
    end

    assign q = q_reg;
endmodule
`default_nettype wire

// >>> verilog/tmo_prescale.sv
`timescale 1ns/100ps
`default_nettype none
module tmo_prescale #(
    parameter int CNT_W = 3
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic clear,
    input wire logic [1:0] sel,
    // ticks
    input wire logic tick_in,
    output logic tick_out
);
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [CNT_W-1:0] mask;

    // divide by 1, 2, 4 or 8
    assign mask = CNT_W'((1 << sel) - 1);
    assign tick_out = tick_in && ((cnt_reg & mask) == mask);
    assign cnt_next = clear ? '0 : (tick_in ? cnt_reg + 1'b1 : cnt_reg);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_next;
    end
endmodule
`default_nettype wire

// >>> verilog/tmo_timer.sv
// Behaviour
// - count only while run enable is one; clearing it holds count
// - control bit 7 picks buffered 16-bit access or two byte accesses
// - read-only bit 6 shows system clock comes from local oscillator
// - bits 5-4 divide input clock by 1, 2, 4 or 8
// - bit 3 enables local oscillator; zero shuts it fully off
// - bit 2 bypasses external clock sync; ignored in timer mode
// - source bit zero: timer at Fosc/4; one: counter mode
// - counter mode counts rising edges of pin or local oscillator
// - while run enable is one both clock pins are inputs, direction bits read 0
// - wide mode maps high byte address to a buffer register
// - wide mode low byte read copies live high byte into buffer
// - wide mode low byte write loads high byte from buffer too
// - wide mode live high byte only reachable through the buffer
// - high byte write keeps prescaler; low byte write clears it
// - enabled local oscillator keeps running in power-managed modes
// - control visible only while watchdog alternate select is zero
// - count rolls FFFFh to 0000h, setting latched flag with enable
// - compare trigger resets count only in timer or sync counter
// - software count write beats a simultaneous compare reset
// - compare trigger reset does not set the rollover flag
`timescale 1ns/100ps
`default_nettype none
module tmo_timer (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // oscillator and count clock pins
    input wire logic osc_input_pin_i,
    output logic osc_input_pin_o,
    output logic osc_input_pin_oe,
    input wire logic ext_count_clock_pin_i,
    output logic ext_count_clock_pin_o,
    output logic ext_count_clock_pin_oe,
    // clock controller and compare module
    input wire logic sysclk_from_local_osc_i,
    input wire logic compare_event,
    output logic local_osc_enable_o,
    // rollover
    output logic rollover_flag_o,
    output logic rollover_irq_o
);
    // registers
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic [7:0] hbuf_reg;
    logic [7:0] hbuf_next;
    logic flag_reg;
    logic flag_next;
    logic irq_en_reg;
    logic irq_en_next;
    logic irq_reg;
    logic wdt_alt_reg;
    logic wdt_alt_next;
    logic [1:0] dir_reg;
    logic [1:0] dir_next;
    logic [1:0] latch_reg;
    logic [1:0] latch_next;
    logic [1:0] pin_oe_reg;
    logic [1:0] pin_o_reg;
    logic [1:0] instr_reg;
    logic pend_reg;
    logic pend_next;
    logic src_prev_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;

    // control fields
    logic wide;
    logic run;
    logic osc_en;
    logic sync_byp;
    logic ext_src;
    logic async_mode;
    logic [1:0] div_sel;
    assign wide = ctrl_reg[tmo_pkg::CTRL_WIDE];
    assign run = ctrl_reg[tmo_pkg::CTRL_RUN];
    assign osc_en = ctrl_reg[tmo_pkg::CTRL_OSC_EN];
    assign sync_byp = ctrl_reg[tmo_pkg::CTRL_SYNC_BYP];
    assign ext_src = ctrl_reg[tmo_pkg::CTRL_SRC];
    assign div_sel = ctrl_reg[tmo_pkg::CTRL_DIV_HI:tmo_pkg::CTRL_DIV_LO];
    // bypass only matters with the external source
    assign async_mode = ext_src && sync_byp;

    // pin synchronisers
    logic [tmo_pkg::SYN_W-1:0] syn_d;
    logic [tmo_pkg::SYN_W-1:0] syn_q;
    assign syn_d = {sysclk_from_local_osc_i, ext_count_clock_pin_i,
                    osc_input_pin_i};

    tmo_sync2 #(
        .WIDTH(tmo_pkg::SYN_W)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(syn_d),
        .q(syn_q)
    );

    logic osc_in_s;
    logic ext_pin_s;
    logic sysclk_local_s;
    assign osc_in_s = syn_q[tmo_pkg::SYN_OSC_IN];
    assign ext_pin_s = syn_q[tmo_pkg::SYN_EXT_PIN];
    assign sysclk_local_s = syn_q[tmo_pkg::SYN_SYSCLK];

    // bus decode
    logic setup;
    logic access;
    logic wr;
    logic rd_setup;
    logic sel_ctrl;
    logic sel_low;
    logic sel_high;
    logic sel_roll;
    logic sel_wdt;
    logic sel_port;
    logic mapped;
    logic ctrl_visible;
    assign setup = psel && !penable;
    assign access = psel && penable && pready_reg;
    assign wr = access && pwrite;
    assign rd_setup = setup && !pwrite;
    assign sel_ctrl = paddr == tmo_pkg::OFF_CTRL;
    assign sel_low = paddr == tmo_pkg::OFF_COUNT_LOW;
    assign sel_high = paddr == tmo_pkg::OFF_COUNT_HIGH;
    assign sel_roll = paddr == tmo_pkg::OFF_ROLLOVER;
    assign sel_wdt = paddr == tmo_pkg::OFF_WATCHDOG;
    assign sel_port = paddr == tmo_pkg::OFF_PORT_C;
    assign mapped = sel_ctrl || sel_low || sel_high || sel_roll
                    || sel_wdt || sel_port;
    // alternate register not built here: address reads zero when selected
    assign ctrl_visible = !wdt_alt_reg;

    logic wr_ctrl;
    logic wr_low;
    logic wr_high;
    logic rd_low;
    assign wr_ctrl = wr && sel_ctrl && ctrl_visible;
    assign wr_low = wr && sel_low;
    assign wr_high = wr && sel_high;
    assign rd_low = rd_setup && sel_low;

    // read data
    logic [7:0] ctrl_rd;
    logic [7:0] high_rd;
    logic [31:0] roll_rd;
    logic [31:0] wdt_rd;
    logic [31:0] port_rd;
    logic [31:0] rd_data;
    logic [1:0] pin_level;
    assign ctrl_rd = {ctrl_reg[7], sysclk_local_s, ctrl_reg[5:0]};
    assign high_rd = wide ? hbuf_reg : count_reg[15:8];
    assign roll_rd = (32'(irq_en_reg) << tmo_pkg::ROLL_IRQ_EN)
                     | (32'(flag_reg) << tmo_pkg::ROLL_FLAG);
    assign wdt_rd = 32'(wdt_alt_reg) << tmo_pkg::WDT_ALT_SEL;
    assign pin_level = {ext_pin_s, osc_in_s};
    // claimed pins read as zero in both direction and level
    assign port_rd = run ? (32'(latch_reg) << tmo_pkg::PORT_LATCH_LO)
                   : ((32'(dir_reg) << tmo_pkg::PORT_DIR_LO)
                   | (32'(latch_reg) << tmo_pkg::PORT_LATCH_LO)
                   | (32'(pin_level) << tmo_pkg::PORT_PIN_LO));
    assign rd_data = sel_ctrl ? (ctrl_visible ? 32'(ctrl_rd) : 32'h0)
                   : sel_low ? 32'(count_reg[7:0])
                   : sel_high ? 32'(high_rd)
                   : sel_roll ? roll_rd
                   : sel_wdt ? wdt_rd
                   : sel_port ? port_rd
                   : 32'h0;

    // instruction cycle divider, Fosc/4
    logic instr_tick;
    assign instr_tick = instr_reg == tmo_pkg::INSTR_LAST;

    // count source: local oscillator replaces the pin when enabled
    logic src_level;
    logic src_edge;
    logic sync_tick;
    logic raw_tick;
    assign src_level = osc_en ? osc_in_s : ext_pin_s;
    assign src_edge = src_level && !src_prev_reg;
    // synchronous counter lines the edge up with the instruction cycle
    assign sync_tick = instr_tick && (pend_reg || src_edge);
    assign pend_next = (instr_tick || !ext_src) ? 1'b0
                       : (pend_reg || src_edge);
    assign raw_tick = run && (!ext_src ? instr_tick
                      : (async_mode ? src_edge : sync_tick));

    logic inc;
    tmo_prescale #(
        .CNT_W(3)
    ) u_prescale (
        .clk(clk),
        .rst_n(rst_n),
        .clear(wr_low),
        .sel(div_sel),
        .tick_in(raw_tick),
        .tick_out(inc)
    );

    // compare trigger is unreliable in async counter mode, so ignored
    logic evt_reset;
    logic any_count_wr;
    logic rollover;
    assign evt_reset = compare_event && !async_mode;
    assign any_count_wr = wr_low || (wr_high && !wide);
    assign rollover = inc && (count_reg == tmo_pkg::COUNT_MAX)
                      && !any_count_wr && !evt_reset;

    // count update, software write first
    assign count_next =
        wr_low ? {(wide ? hbuf_reg : count_reg[15:8]),
                  pwdata[7:0]}
        : (wr_high && !wide) ? {pwdata[7:0], count_reg[7:0]}
        : evt_reset ? tmo_pkg::COUNT_ZERO
        : inc ? count_reg + 16'h0001
        : count_reg;

    // high byte buffer
    assign hbuf_next = (wr_high && wide) ? pwdata[7:0]
                     : (rd_low && wide) ? count_reg[15:8]
                     : hbuf_reg;

    // control: bit 6 is never stored, it mirrors the clock controller
    assign ctrl_next = wr_ctrl ? (pwdata[7:0]
                       & ~(8'h01 << tmo_pkg::CTRL_SYSCLK)) : ctrl_reg;

    // rollover flag: write one to clear, a new rollover wins
    logic flag_clr;
    assign flag_clr = wr && sel_roll && pwdata[tmo_pkg::ROLL_FLAG];
    assign flag_next = rollover || (flag_reg && !flag_clr);
    assign irq_en_next = (wr && sel_roll) ? pwdata[tmo_pkg::ROLL_IRQ_EN]
                         : irq_en_reg;

    assign wdt_alt_next = (wr && sel_wdt) ? pwdata[tmo_pkg::WDT_ALT_SEL]
                          : wdt_alt_reg;
    assign dir_next = (wr && sel_port)
        ? pwdata[tmo_pkg::PORT_DIR_LO +: 2] : dir_reg;
    assign latch_next = (wr && sel_port)
        ? pwdata[tmo_pkg::PORT_LATCH_LO +: 2] : latch_reg;

    // direction bit zero drives the pin unless the timer claims it
    logic [1:0] pin_oe_next;
    assign pin_oe_next = run ? 2'h0 : ~dir_reg;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_reg <= tmo_pkg::CTRL_RESET;
            count_reg <= tmo_pkg::COUNT_ZERO;
            hbuf_reg <= 8'h00;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            count_reg <= count_next;
            hbuf_reg <= hbuf_next;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flag_reg <= 1'b0;
            irq_en_reg <= 1'b0;
            irq_reg <= 1'b0;
            wdt_alt_reg <= 1'b0;
        end
        else
        begin
            flag_reg <= flag_next;
            irq_en_reg <= irq_en_next;
            irq_reg <= flag_next && irq_en_next;
            wdt_alt_reg <= wdt_alt_next;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            instr_reg <= 2'h0;
            pend_reg <= 1'b0;
            src_prev_reg <= 1'b0;
        end
        else
        begin
            instr_reg <= instr_reg + 2'h1;
            pend_reg <= pend_next;
            src_prev_reg <= src_level;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dir_reg <= tmo_pkg::PORT_DIR_RESET;
            latch_reg <= tmo_pkg::PORT_LATCH_RESET;
            pin_oe_reg <= 2'h0;
            pin_o_reg <= 2'h0;
        end
        else
        begin
            dir_reg <= dir_next;
            latch_reg <= latch_next;
            pin_oe_reg <= pin_oe_next;
            pin_o_reg <= latch_reg;
        end
    end

    // read data is registered during setup, so no wait state is needed
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata_reg <= 32'h0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            pready_reg <= setup;
            pslverr_reg <= setup && !mapped;
            if (rd_setup)
                prdata_reg <= rd_data;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign osc_input_pin_o = pin_o_reg[0];
    assign osc_input_pin_oe = pin_oe_reg[0];
    assign ext_count_clock_pin_o = pin_o_reg[1];
    assign ext_count_clock_pin_oe = pin_oe_reg[1];
    // no power-mode gating: the oscillator stays on while enabled
    assign local_osc_enable_o = ctrl_reg[tmo_pkg::CTRL_OSC_EN];
    assign rollover_flag_o = flag_reg;
    assign rollover_irq_o = irq_reg;
endmodule
`default_nettype wire

// >>> test/tmo_timer_sva.sv
`timescale 1ns/100ps
`default_nettype none
module tmo_timer_sva (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins and flags
    input wire logic osc_input_pin_oe,
    input wire logic ext_count_clock_pin_oe,
    input wire logic local_osc_enable_o,
    input wire logic rollover_flag_o,
    input wire logic rollover_irq_o
);
    logic done;
    logic ctrl_wr;
    logic ctrl_rd;
    logic clr_wr;
    logic osc_bit;
    logic mapped;
    logic alt_reg;
    logic run_reg;
    assign done = psel && penable && pready;
    assign ctrl_wr = done && pwrite && paddr == tmo_pkg::OFF_CTRL;
    assign ctrl_rd = done && !pwrite && paddr == tmo_pkg::OFF_CTRL;
    assign clr_wr = done && pwrite && paddr == tmo_pkg::OFF_ROLLOVER
        && pwdata[tmo_pkg::ROLL_FLAG];
    assign osc_bit = pwdata[tmo_pkg::CTRL_OSC_EN];
    assign mapped = paddr[1:0] == 2'h0 && paddr <= tmo_pkg::OFF_PORT_C;
    // mirror of the alternate select and run bit, as software set them
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            alt_reg <= 1'b0;
            run_reg <= 1'b0;
        end
        else
        begin
            if (done && pwrite && paddr == tmo_pkg::OFF_WATCHDOG)
                alt_reg <= pwdata[tmo_pkg::WDT_ALT_SEL];
            if (ctrl_wr && !alt_reg)
                run_reg <= pwdata[tmo_pkg::CTRL_RUN];
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    pready_answer_a: assert property (psel && !penable |=> pready)
        else $error("no pready one cycle after setup");
    unmapped_error_a: assert property (done && !mapped |-> pslverr)
        else $error("unmapped access without slave error");
    osc_enable_a: assert property (ctrl_wr && !alt_reg |=>
        local_osc_enable_o == $past(osc_bit))
        else $error("oscillator enable not taken from control write");
    osc_steady_a: assert property ($changed(local_osc_enable_o)
        |-> $past(ctrl_wr))
        else $error("oscillator enable changed without control write");
    pins_input_a: assert property (run_reg && $past(run_reg) |->
        !osc_input_pin_oe && !ext_count_clock_pin_oe)
        else $error("clock pin driven while timer runs");
    ctrl_hidden_a: assert property (alt_reg && ctrl_wr |=>
        $stable(local_osc_enable_o))
        else $error("hidden control register accepted a write");
    ctrl_read_hidden_a: assert property (alt_reg && ctrl_rd |->
        prdata == 32'h0000_0000)
        else $error("hidden control register returned data");
    irq_gate_a: assert property (rollover_irq_o |-> rollover_flag_o)
        else $error("interrupt without rollover flag");
    flag_sticky_a: assert property (rollover_flag_o && !clr_wr
        |=> rollover_flag_o)
        else $error("rollover flag dropped without clear");
    cover property (ctrl_wr && !alt_reg);
    cover property ($rose(rollover_flag_o));
    cover property (done && pslverr);
endmodule
bind tmo_timer tmo_timer_sva i_tmo_timer_sva (
    .clk(clk),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .osc_input_pin_oe(osc_input_pin_oe),
    .ext_count_clock_pin_oe(ext_count_clock_pin_oe),
    .local_osc_enable_o(local_osc_enable_o),
    .rollover_flag_o(rollover_flag_o),
    .rollover_irq_o(rollover_irq_o)
);
`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, last_err;
    logic osc_pin, ext_pin, sysclk_in, compare_event, ce_on_write;
    logic osc_o, osc_oe, ext_o, ext_oe, osc_en, flag, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, cnt, cnt2;
    int errors, samples_checked;
    tmo_timer i_tmo_timer (
        .clk(clk),
        .rst_n(rst_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .osc_input_pin_i(osc_pin),
        .osc_input_pin_o(osc_o),
        .osc_input_pin_oe(osc_oe),
        .ext_count_clock_pin_i(ext_pin),
        .ext_count_clock_pin_o(ext_o),
        .ext_count_clock_pin_oe(ext_oe),
        .sysclk_from_local_osc_i(sysclk_in),
        .compare_event(compare_event),
        .local_osc_enable_o(osc_en),
        .rollover_flag_o(flag),
        .rollover_irq_o(irq)
    );
    task automatic wrap_up();
        if (errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        compare_event <= ce_on_write;
        // only the watchdog ends a wait that never sees pready
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        compare_event <= 1'b0;
        // one idle edge so the next request never lands in this time step
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rchk(input string what, input logic [7:0] a,
        input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask
    // byte mode only, and only with the timer stopped, to avoid tearing
    task automatic get_count(output logic [31:0] c);
        apb(1'b0, tmo_pkg::OFF_COUNT_LOW, 32'h0);
        c = {24'h0, rd[7:0]};
        apb(1'b0, tmo_pkg::OFF_COUNT_HIGH, 32'h0);
        c[15:8] = rd[7:0];
    endtask
    task automatic pulses(input int n, input logic use_osc);
        repeat (n)
        begin
            {osc_pin, ext_pin} <= use_osc ? 2'b10 : 2'b01;
            repeat (8) @(posedge clk);
            {osc_pin, ext_pin} <= 2'b00;
            repeat (8) @(posedge clk);
        end
    endtask
    task automatic pulse_ce();
        compare_event <= 1'b1;
        @(posedge clk);
        compare_event <= 1'b0;
        @(posedge clk);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        #200000;
        errors++;
        wrap_up();
    end
    initial
    begin
        rst_n = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {osc_pin, ext_pin, sysclk_in, compare_event, ce_on_write} = '0;
        errors = 0;
        samples_checked = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rchk("control reset", tmo_pkg::OFF_CTRL, 32'h0);
        rchk("port reset", tmo_pkg::OFF_PORT_C, 32'h3);
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, last_err});
        chk("unmapped data", 32'h0, rd);
        wr(tmo_pkg::OFF_COUNT_HIGH, 32'h12);
        wr(tmo_pkg::OFF_COUNT_LOW, 32'h34);
        get_count(cnt);
        chk("byte count", 32'h1234, cnt);
        wr(tmo_pkg::OFF_CTRL, 32'h80);
        wr(tmo_pkg::OFF_COUNT_HIGH, 32'hAB);
        rchk("high buffer", tmo_pkg::OFF_COUNT_HIGH, 32'hAB);
        wr(tmo_pkg::OFF_CTRL, 32'h0);
        get_count(cnt);
        chk("live high untouched", 32'h1234, cnt);
        wr(tmo_pkg::OFF_CTRL, 32'h80);
        wr(tmo_pkg::OFF_COUNT_HIGH, 32'hAB);
        wr(tmo_pkg::OFF_COUNT_LOW, 32'hCD);
        wr(tmo_pkg::OFF_COUNT_HIGH, 32'h55);
        rchk("wide low", tmo_pkg::OFF_COUNT_LOW, 32'hCD);
        rchk("latched high", tmo_pkg::OFF_COUNT_HIGH, 32'hAB);
        wr(tmo_pkg::OFF_CTRL, 32'h0);
        get_count(cnt);
        chk("wide write", 32'hABCD, cnt);
        wr(tmo_pkg::OFF_COUNT_HIGH, 32'h0);
        // 40 clocks per step of the divider: ten counts, one either way
        for (int k = 0; k < 4; k++)
        begin
            wr(tmo_pkg::OFF_COUNT_LOW, 32'h0);
            wr(tmo_pkg::OFF_CTRL, 32'(k << 4) | 32'h1);
            repeat (40 * (1 << k) - 3) @(posedge clk);
            wr(tmo_pkg::OFF_CTRL, 32'h0);
            get_count(cnt);
            chk("divided count", 32'h1, 32'(cnt >= 9 && cnt <= 11));
        end
        repeat (20) @(posedge clk);
        get_count(cnt2);
        chk("stopped count", cnt, cnt2);
        wr(tmo_pkg::OFF_COUNT_HIGH, 32'hFF);
        wr(tmo_pkg::OFF_COUNT_LOW, 32'hF8);
        wr(tmo_pkg::OFF_CTRL, 32'h1);
        repeat (40) @(posedge clk);
        wr(tmo_pkg::OFF_CTRL, 32'h0);
        chk("rollover flag", 32'h1, {31'h0, flag});
        get_count(cnt);
        chk("wrapped count", 32'h1, 32'(cnt < 32'h10));
        wr(tmo_pkg::OFF_ROLLOVER, 32'h2);
        chk("irq enabled", 32'h1, {31'h0, irq});
        wr(tmo_pkg::OFF_ROLLOVER, 32'h3);
        chk("flag cleared", 32'h0, {30'h0, flag, irq});
        wr(tmo_pkg::OFF_COUNT_HIGH, 32'h12);
        wr(tmo_pkg::OFF_COUNT_LOW, 32'h34);
        pulse_ce();
        get_count(cnt);
        chk("compare reset", 32'h0, cnt);
        chk("compare no flag", 32'h0, {31'h0, flag});
        wr(tmo_pkg::OFF_COUNT_HIGH, 32'h12);
        ce_on_write = 1'b1;
        wr(tmo_pkg::OFF_COUNT_LOW, 32'h56);
        ce_on_write = 1'b0;
        get_count(cnt);
        chk("write beats compare", 32'h1256, cnt);
        wr(tmo_pkg::OFF_CTRL, 32'h06);
        pulse_ce();
        get_count(cnt);
        chk("async ignores compare", 32'h1256, cnt);
        wr(tmo_pkg::OFF_CTRL, 32'h03);
        pulses(5, 1'b0);
        wr(tmo_pkg::OFF_CTRL, 32'h0);
        get_count(cnt);
        chk("sync pin count", 32'h125B, cnt);
        wr(tmo_pkg::OFF_CTRL, 32'h07);
        pulses(3, 1'b0);
        wr(tmo_pkg::OFF_CTRL, 32'h0);
        get_count(cnt);
        chk("async pin count", 32'h125E, cnt);
        wr(tmo_pkg::OFF_CTRL, 32'h08);
        chk("osc enabled", 32'h1, {31'h0, osc_en});
        repeat (16) @(posedge clk);
        wr(tmo_pkg::OFF_CTRL, 32'h0B);
        pulses(4, 1'b1);
        wr(tmo_pkg::OFF_CTRL, 32'h0);
        chk("osc off", 32'h0, {31'h0, osc_en});
        get_count(cnt);
        chk("osc count", 32'h1262, cnt);
        wr(tmo_pkg::OFF_PORT_C, 32'h30);
        // pin drive follows the port register one edge later
        @(posedge clk);
        chk("pins driven", 32'hF, {28'h0, osc_oe, ext_oe, osc_o, ext_o});
        wr(tmo_pkg::OFF_CTRL, 32'h1);
        rchk("port while run", tmo_pkg::OFF_PORT_C, 32'h30);
        chk("pins forced in", 32'h0, {30'h0, osc_oe, ext_oe});
        wr(tmo_pkg::OFF_CTRL, 32'h0);
        sysclk_in <= 1'b1;
        wr(tmo_pkg::OFF_CTRL, 32'h88);
        rchk("status bit", tmo_pkg::OFF_CTRL, 32'hC8);
        wr(tmo_pkg::OFF_WATCHDOG, 32'h10);
        rchk("control hidden", tmo_pkg::OFF_CTRL, 32'h0);
        wr(tmo_pkg::OFF_CTRL, 32'h0);
        wr(tmo_pkg::OFF_WATCHDOG, 32'h0);
        rchk("control kept", tmo_pkg::OFF_CTRL, 32'hC8);
        // divide by 8 in async counter mode: four edges, then four more
        wr(tmo_pkg::OFF_COUNT_LOW, 32'h0);
        wr(tmo_pkg::OFF_CTRL, 32'h37);
        pulses(4, 1'b0);
        wr(tmo_pkg::OFF_CTRL, 32'h0);
        wr(tmo_pkg::OFF_COUNT_HIGH, 32'h0);
        wr(tmo_pkg::OFF_CTRL, 32'h37);
        pulses(4, 1'b0);
        wr(tmo_pkg::OFF_CTRL, 32'h0);
        get_count(cnt);
        chk("high write keeps divider", 32'h1, cnt);
        wrap_up();
    end
endmodule
`default_nettype wire
